// [verilog/reset_brownout_protect_ctrl.v]
// How it works
// - four sources can raise chip reset
// - hold reset until pin, oscillator, count, flash
// - fetch starts at address zero after release
// - registers hold reset values at release
// - first supply threshold raises interrupt request
// - interrupt gated by enable, status always readable
// - second threshold forces reset, flash writes blocked
// - supply-drop reset held, power-on covers below
// - both thresholds filtered, second-threshold reset taken unfiltered
// - guard level from flash pattern; app calls free
// - level one: no debug, loader spares sector 0
// - level two: no debug, erase-all then update
// - level three: no debug, no loader, no override
`timescale 1ns/1ns
`default_nettype none
`include "reset_guard_defs.vh"

module reset_brownout_protect_ctrl #(
  parameter [15:0] WAKE_CYCLES   = `WAKE_COUNT,
  parameter [7:0]  FILTER_CYCLES = `LEVEL_FILTER_CYCLES
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        resetPinN,
  input  wire        watchdogReset,
  input  wire        powerOnReset,
  input  wire        supplyBelowFirst,
  input  wire        supplyBelowSecond,
  input  wire        oscReady,
  input  wire        flashInitDone,
  input  wire [31:0] guardWord,
  input  wire        guardWordValid,
  input  wire        dropIrqEnable,
  input  wire        debugRequest,
  input  wire        loaderCmdValid,
  input  wire [2:0]  loaderCmd,
  input  wire [4:0]  loaderSector,
  input  wire        forceLoaderPin,
  input  wire        appFlashCall,
  output wire        chipResetN,
  output reg         sysResetN,
  output reg  [31:0] bootFetchAddr,
  output reg         flashInitStart,
  output reg         dropIrq,
  output reg         dropStatus,
  output reg  [3:0]  resetCause,
  output reg         flashWriteBlock,
  output reg  [1:0]  guardLevel,
  output reg         debugEnable,
  output wire        loaderCmdAccept,
  output wire        loaderCmdReject,
  output reg         loaderEntry,
  output reg         appFlashAllowed
);

  localparam [3:0] ST_HOLD  = 4'b0001;
  localparam [3:0] ST_COUNT = 4'b0010;
  localparam [3:0] ST_FLASH = 4'b0100;
  localparam [3:0] ST_RUN   = 4'b1000;

  // decodes the flash guard word into a level
  function [1:0] guardDecode;
    input [31:0] word;
    begin
      case (word)
        `GUARD_ONE_PATTERN:   guardDecode = `GUARD_LVL_ONE;
        `GUARD_TWO_PATTERN:   guardDecode = `GUARD_LVL_TWO;
        `GUARD_THREE_PATTERN: guardDecode = `GUARD_LVL_THREE;
        default:              guardDecode = `GUARD_LVL_NONE;
      endcase
    end
  endfunction

  wire dropFirst;
  wire dropSecond;

  level_filter #(.FILTER_CYCLES(FILTER_CYCLES)) firstFilter (
    .clk      (clk),
    .reset    (reset),
    .levelIn  (supplyBelowFirst),
    .levelOut (dropFirst)
  );

  level_filter #(.FILTER_CYCLES(FILTER_CYCLES)) secondFilter (
    .clk      (clk),
    .reset    (reset),
    .levelIn  (supplyBelowSecond),
    .levelOut (dropSecond)
  );

  // async OR of sources
  // the second-threshold level reaches the merge directly so a dying supply needs no clock
  assign chipResetN = ~(reset | ~resetPinN | watchdogReset | powerOnReset
                        | supplyBelowSecond);

  // release of the merged reset passes two flops
  reg relSync1_q;
  reg relSync2_q;
  always @(posedge clk or negedge chipResetN) begin
    if (!chipResetN) begin
      relSync1_q <= 1'b0;
      relSync2_q <= 1'b0;
    end else begin
      relSync1_q <= 1'b1;
      relSync2_q <= relSync1_q;
    end
  end

  // pin and status inputs synchronised
  reg pinS1_q, pinS2_q, oscS1_q, oscS2_q, flS1_q, flS2_q;
  reg forceS1_q, forceS2_q;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pinS1_q   <= 1'b1; // idle level, no false pin cause
      pinS2_q   <= 1'b1;
      oscS1_q   <= 1'b0;
      oscS2_q   <= 1'b0;
      flS1_q    <= 1'b0;
      flS2_q    <= 1'b0;
      forceS1_q <= 1'b0;
      forceS2_q <= 1'b0;
    end else begin
      pinS1_q   <= resetPinN;
      pinS2_q   <= pinS1_q;
      oscS1_q   <= oscReady;
      oscS2_q   <= oscS1_q;
      flS1_q    <= flashInitDone;
      flS2_q    <= flS1_q;
      forceS1_q <= forceLoaderPin;
      forceS2_q <= forceS1_q;
    end
  end

  reg [3:0]  state_q;
  reg [15:0] wake_q;

  always @(posedge clk or negedge relSync2_q) begin
    if (!relSync2_q) begin
      state_q        <= ST_HOLD;
      wake_q         <= 16'h0000;
      flashInitStart <= 1'b0;
      sysResetN      <= 1'b0;
      bootFetchAddr  <= `BOOT_VECTOR_ADDR;
    end else begin
      case (state_q)
        ST_HOLD: begin
          wake_q <= 16'h0000;
          if (pinS2_q && oscS2_q) begin
            state_q <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (!pinS2_q || !oscS2_q) begin
            state_q <= ST_HOLD;
          end else if (wake_q >= WAKE_CYCLES - 16'h0001) begin
            state_q        <= ST_FLASH;
            flashInitStart <= 1'b1;
          end else begin
            wake_q <= wake_q + 16'h0001;
          end
        end
        ST_FLASH: begin
          flashInitStart <= 1'b0;
          if (flS2_q) begin
            state_q   <= ST_RUN;
            sysResetN <= 1'b1;
          end
        end
        ST_RUN: begin
          bootFetchAddr <= `BOOT_VECTOR_ADDR;
          sysResetN     <= 1'b1;
        end
        default: begin
          state_q <= ST_HOLD;
        end
      endcase
    end
  end

  // cause capture: sticky flags survive the reset they report
  reg wdS1_q, wdS2_q, porS1_q, porS2_q;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wdS1_q     <= 1'b0;
      wdS2_q     <= 1'b0;
      porS1_q    <= 1'b0;
      porS2_q    <= 1'b0;
      resetCause <= 4'h0;
    end else begin
      wdS1_q  <= watchdogReset;
      wdS2_q  <= wdS1_q;
      porS1_q <= powerOnReset;
      porS2_q <= porS1_q;
      if (porS2_q) begin
        resetCause <= 4'h1;
      end else begin
        resetCause <= resetCause | {dropSecond, wdS2_q, ~pinS2_q, 1'b0};
      end
    end
  end

  // state below cleared by the held reset
  always @(posedge clk or negedge relSync2_q) begin
    if (!relSync2_q) begin
      dropIrq         <= 1'b0;
      dropStatus      <= 1'b0;
      flashWriteBlock <= 1'b1;
      guardLevel      <= `GUARD_LVL_THREE;
      debugEnable     <= 1'b0;
      loaderEntry     <= 1'b0;
      appFlashAllowed <= 1'b0;
    end else begin
      dropStatus <= dropFirst;
      dropIrq    <= dropFirst & dropIrqEnable;
      // flash write block on deep drop
      flashWriteBlock <= dropSecond | ~sysResetN;
      if (guardWordValid && state_q == ST_FLASH && flS2_q) begin
        guardLevel <= guardDecode(guardWord);
      end
      debugEnable <= sysResetN && (guardLevel == `GUARD_LVL_NONE);
      // override pin ignored at level three
      loaderEntry <= sysResetN && forceS2_q && (guardLevel != `GUARD_LVL_THREE);
      appFlashAllowed <= sysResetN & appFlashCall & ~dropSecond;
    end
  end

  reg cmdOk;
  always @* begin
    cmdOk = 1'b0;
    case (guardLevel)
      `GUARD_LVL_NONE: cmdOk = 1'b1;
      `GUARD_LVL_ONE: cmdOk = (loaderCmd == `LOADER_CMD_ERASEALL)
                            || (loaderCmd == `LOADER_CMD_GO)
                            || (loaderCmd == `LOADER_CMD_INFO)
                            || (((loaderCmd == `LOADER_CMD_WRITE)
                                 || (loaderCmd == `LOADER_CMD_ERASE))
                                && (loaderSector != 5'h00));
      `GUARD_LVL_TWO: cmdOk = (loaderCmd == `LOADER_CMD_ERASEALL)
                            || (loaderCmd == `LOADER_CMD_WRITE)
                            || (loaderCmd == `LOADER_CMD_INFO);
      `GUARD_LVL_THREE: cmdOk = 1'b0;
      default: cmdOk = 1'b0;
    endcase
  end

  reg erased_q;
  always @(posedge clk or negedge relSync2_q) begin
    if (!relSync2_q) begin
      erased_q <= 1'b0;
    end else if (loaderCmdValid && cmdOk && loaderCmd == `LOADER_CMD_ERASEALL) begin
      erased_q <= 1'b1;
    end
  end

  wire needErase = (guardLevel == `GUARD_LVL_TWO) && (loaderCmd == `LOADER_CMD_WRITE);
  wire cmdPass   = cmdOk && (!needErase || erased_q) && sysResetN && !dropSecond;

  assign loaderCmdAccept = loaderCmdValid & cmdPass;
  assign loaderCmdReject = loaderCmdValid & ~cmdPass;

endmodule // reset_brownout_protect_ctrl

`default_nettype wire

// [shared/reset_guard_defs.vh]
`ifndef RESET_GUARD_DEFS_VH
`define RESET_GUARD_DEFS_VH

// wake-up clock count after oscillator is good
`define WAKE_COUNT          16'h1000
// boot fetch address
`define BOOT_VECTOR_ADDR    32'h0000_0000
// default length of the comparator level filter
`define LEVEL_FILTER_CYCLES 8'h10

// guard level pattern words in the dedicated flash word
`define GUARD_ONE_PATTERN   32'h1234_5678
`define GUARD_TWO_PATTERN   32'h8765_4321
`define GUARD_THREE_PATTERN 32'h4321_8765

// guard level codes
`define GUARD_LVL_NONE      2'h0
`define GUARD_LVL_ONE       2'h1
`define GUARD_LVL_TWO       2'h2
`define GUARD_LVL_THREE     2'h3

// loader command classes
`define LOADER_CMD_READ     3'h0
`define LOADER_CMD_WRITE    3'h1
`define LOADER_CMD_ERASE    3'h2
`define LOADER_CMD_ERASEALL 3'h3
`define LOADER_CMD_GO       3'h4
`define LOADER_CMD_INFO     3'h5

`endif

// [verilog/level_filter.v]
`timescale 1ns/1ns
`default_nettype none
`include "reset_guard_defs.vh"

// synchronises a comparator level and holds it until it has been stable
module level_filter #(
  parameter [7:0] FILTER_CYCLES = `LEVEL_FILTER_CYCLES
) (
  input  wire clk,
  input  wire reset,
  input  wire levelIn,
  output reg  levelOut
);

  reg       sync1_q;
  reg       sync2_q;
  reg [7:0] count_q;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_q  <= 1'b0;
      sync2_q  <= 1'b0;
      count_q  <= 8'h00;
      levelOut <= 1'b0;
    end else begin
      sync1_q <= levelIn;
      sync2_q <= sync1_q;
      if (sync2_q == levelOut) begin
        count_q <= 8'h00;
      end else if (count_q >= FILTER_CYCLES - 8'h01) begin
        count_q  <= 8'h00;
        levelOut <= sync2_q;
      end else begin
        count_q <= count_q + 8'h01;
      end
    end
  end

endmodule // level_filter

`default_nettype wire

// [verification/reset_guard_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module reset_guard_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        resetPinN,
  input wire logic        watchdogReset,
  input wire logic        powerOnReset,
  input wire logic        supplyBelowFirst,
  input wire logic        supplyBelowSecond,
  input wire logic        dropIrqEnable,
  input wire logic        loaderCmdValid,
  input wire logic        chipResetN,
  input wire logic        sysResetN,
  input wire logic [31:0] bootFetchAddr,
  input wire logic        flashInitStart,
  input wire logic        dropIrq,
  input wire logic        dropStatus,
  input wire logic        flashWriteBlock,
  input wire logic [1:0]  guardLevel,
  input wire logic        debugEnable,
  input wire logic        loaderCmdAccept
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_pin_merge: assert property (!resetPinN |-> !chipResetN) else $error("pin reset lost");
  a_wdog_merge: assert property (watchdogReset |-> !chipResetN) else $error("wdog lost");
  a_por_merge: assert property (powerOnReset |-> !chipResetN) else $error("por lost");
  a_deep_block: assert property (supplyBelowSecond |=> flashWriteBlock && !sysResetN)
    else $error("deep drop not blocking");
  a_hold_internal: assert property (!chipResetN |=> !sysResetN) else $error("early release");
  a_boot_zero: assert property (sysResetN |-> bootFetchAddr == 32'h0) else $error("boot addr");
  a_irq_gate: assert property (!$past(dropIrqEnable) |-> !dropIrq) else $error("irq ungated");
  a_irq_status: assert property (dropIrq |-> dropStatus) else $error("irq w/o status");
  a_drop_filter: assert property ($rose(dropStatus) |-> $past(supplyBelowFirst, 2)
    && $past(supplyBelowFirst, 3)) else $error("unfiltered drop");
  a_debug_lock: assert property (guardLevel != 2'h0 |-> !debugEnable) else $error("debug open");
  a_lvl3_loader: assert property (guardLevel == 2'h3 && loaderCmdValid |-> !loaderCmdAccept)
    else $error("loader open");
  a_init_pulse: assert property (flashInitStart |=> !flashInitStart) else $error("long pulse");
  c_boot: cover property ($rose(sysResetN));
  c_irq: cover property ($rose(dropIrq));
  c_deep: cover property (supplyBelowSecond);
endmodule // reset_guard_chk
bind reset_brownout_protect_ctrl reset_guard_chk chk_u (.*);
`default_nettype wire

// [verification/flash_osc_model.sv]
`timescale 1ns/1ns
`default_nettype none
module flash_osc_model (
  input wire logic  clk,
  input wire logic  powerOnReset,
  input wire logic  chipResetN,
  input wire logic  flashInitStart,
  output logic      oscReady,
  output logic      flashInitDone
);
  logic [2:0] oscCnt_q;
  logic [2:0] initCnt_q;
  always @(posedge clk or posedge powerOnReset) begin
    if (powerOnReset) oscCnt_q <= 3'h0;
    else if (oscCnt_q != 3'h7) oscCnt_q <= oscCnt_q + 3'h1;
  end
  assign oscReady = (oscCnt_q == 3'h7);
  // flash init is slow, restarts on reset
  always @(posedge clk or negedge chipResetN) begin
    if (!chipResetN) initCnt_q <= 3'h0;
    else if (flashInitStart) initCnt_q <= 3'h1;
    else if (initCnt_q != 3'h0 && initCnt_q != 3'h5) initCnt_q <= initCnt_q + 3'h1;
  end
  assign flashInitDone = (initCnt_q == 3'h5);
endmodule // flash_osc_model
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "reset_guard_defs.vh"
module testbench;
  logic clk, reset, resetPinN, watchdogReset, powerOnReset, supplyBelowFirst, supplyBelowSecond;
  logic guardWordValid, dropIrqEnable, debugRequest, loaderCmdValid, forceLoaderPin, appFlashCall;
  logic [31:0] guardWord;
  logic [2:0]  loaderCmd;
  logic [4:0]  loaderSector;
  wire oscReady, flashInitDone, chipResetN, sysResetN, flashInitStart, dropIrq, dropStatus;
  wire flashWriteBlock, debugEnable, loaderCmdAccept, loaderCmdReject, loaderEntry, appFlashAllowed;
  wire [31:0] bootFetchAddr;
  wire [3:0]  resetCause;
  wire [1:0]  guardLevel;
  int error_cnt, checked, cyc;
  logic [31:0] pats [4] = '{32'h0, `GUARD_ONE_PATTERN, `GUARD_TWO_PATTERN, `GUARD_THREE_PATTERN};
  logic [2:0] ca [4] = '{`LOADER_CMD_READ, `LOADER_CMD_WRITE,
                         `LOADER_CMD_WRITE, `LOADER_CMD_ERASEALL};
  logic [4:0] sa [4] = '{5'h0, 5'h0, 5'h1, 5'h0};
  logic       ea [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
  logic [2:0] cb [4] = '{`LOADER_CMD_WRITE, `LOADER_CMD_WRITE,
                         `LOADER_CMD_ERASEALL, `LOADER_CMD_GO};
  logic       eb [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  logic [2:0] cc [4] = '{`LOADER_CMD_ERASE, `LOADER_CMD_READ,
                         `LOADER_CMD_WRITE, `LOADER_CMD_WRITE};
  logic       ec [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [2:0] cd [4] = '{`LOADER_CMD_GO, `LOADER_CMD_ERASE,
                         `LOADER_CMD_READ, `LOADER_CMD_INFO};
  logic       ed [4] = '{1'b1, 1'b0, 1'b0, 1'b0};

  reset_brownout_protect_ctrl #(.WAKE_CYCLES(16'h0010), .FILTER_CYCLES(8'h02)) dut_u (.*);
  flash_osc_model fm_u (.*);

  initial begin clk = 0; forever #5 clk = ~clk; end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin error_cnt++; tally_and_finish; end
  end

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin error_cnt++; $display("MISMATCH %s exp %h seen %h", n, e, s); end
  endtask
  task step(input int n); repeat (n) @(posedge clk); #1; endtask
  task wait_boot; int k; k = 0;
    while (sysResetN !== 1'b1 && k < 200) begin step(1); k++; end
    chk("sysResetN", sysResetN, 1);
    step(1);
  endtask
  task loader(input logic [2:0] c, input logic [4:0] s, input logic e);
    loaderCmd = c; loaderSector = s; loaderCmdValid = 1; #1;
    chk("accept", loaderCmdAccept, e);
    chk("reject", loaderCmdReject, !e);
    step(1);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task guard_levels; for (int l = 0; l < 4; l++) begin
    guardWord = pats[l]; watchdogReset = 1; step(2);
    chk("chipResetN", chipResetN, 0);
    watchdogReset = 0; wait_boot;
    chk("cause2", resetCause[2], 1);
    chk("guardLevel", guardLevel, l);
    chk("debugEnable", debugEnable, l == 0);
    loader(ca[l], sa[l], ea[l]);
    loader(cb[l], 5'h1, eb[l]);
    loader(cc[l], 5'h1, ec[l]);
    loader(cd[l], 5'h0, ed[l]);
    loaderCmdValid = 0; forceLoaderPin = 1; appFlashCall = 1; step(4);
    chk("loaderEntry", loaderEntry, l != 3);
    chk("appFlash", appFlashAllowed, 1);
    forceLoaderPin = 0; appFlashCall = 0;
  end
  endtask
  task supply_drop;
    dropIrqEnable = 1; supplyBelowFirst = 1; step(1); supplyBelowFirst = 0; step(8);
    chk("glitch", dropStatus, 0);
    supplyBelowFirst = 1; step(8);
    chk("dropStatus", dropStatus, 1);
    chk("dropIrq", dropIrq, 1);
    dropIrqEnable = 0; step(2);
    chk("masked", dropIrq, 0);
    chk("status", dropStatus, 1);
    supplyBelowFirst = 0; supplyBelowSecond = 1; #1;
    chk("deep", chipResetN, 0);
    step(2);
    chk("wblock", flashWriteBlock, 1);
    supplyBelowSecond = 0; wait_boot;
    chk("cause3", resetCause[3], 1);
  endtask
  task pin_hold;
    resetPinN = 0; step(40);
    chk("pinHold", sysResetN, 0);
    resetPinN = 1; wait_boot;
    chk("cause1", resetCause[1], 1);
  endtask

  initial begin
    {reset, powerOnReset, resetPinN, guardWordValid} = 4'hF;
    {watchdogReset, supplyBelowFirst, supplyBelowSecond, dropIrqEnable, debugRequest} = 5'h0;
    {loaderCmdValid, forceLoaderPin, appFlashCall, loaderCmd, loaderSector} = 11'h0;
    guardWord = 32'h0;
    step(5); reset = 0; step(4); powerOnReset = 0; wait_boot;
    chk("bootAddr", bootFetchAddr, 32'h0);
    chk("cause0", resetCause[0], 1);
    chk("wblock0", flashWriteBlock, 0);
    guard_levels; supply_drop; pin_hold;
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
